// file: common/dsm_defines.svh
// register offsets, field positions, reset values and codes for the carrier stage
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH

`define DSM_OFF_CON0        12'h000
`define DSM_OFF_CON1        12'h004
`define DSM_OFF_SRC         12'h008
`define DSM_OFF_CARH        12'h00C
`define DSM_OFF_CARL        12'h010

`define DSM_CON0_EN         7
`define DSM_CON0_OUT        5
`define DSM_CON0_OUTPUT_INVERT       4
`define DSM_CON0_BIT        0
`define DSM_CON1_HIGH_CARRIER_INVERT      5
`define DSM_CON1_HIGH_CARRIER_EDGE_WAIT     4
`define DSM_CON1_LOW_CARRIER_INVERT      1
`define DSM_CON1_LOW_CARRIER_EDGE_WAIT     0

`define DSM_CON_RESET       8'h00
`define DSM_CODE_RESET      5'h00

`define DSM_CODE_PIN        5'h00
`define DSM_CODE_SYSCLK     5'h01
`define DSM_CODE_FASTOSC    5'h02
`define DSM_CODE_CCP_FIRST  5'h03
`define DSM_CODE_PWM_FIRST  5'h07
`define DSM_CODE_LC_FIRST   5'h0F
`define DSM_CODE_LAST       5'h12

`define DSM_MS_PIN          5'h00
`define DSM_MS_SWBIT        5'h01
`define DSM_MS_LAST         5'h1A

`define DSM_RESP_OKAY       2'h0
`define DSM_RESP_SLVERR     2'h2

`endif

// file: common/dsm_pkg.sv
// types shared by the carrier-select stage
package dsm_pkg;
    typedef struct packed {
        logic       pin;
        logic       fast_osc;
        logic [3:0] ccp;
        logic [7:0] pwm;
        logic [3:0] lc;
    } dsm_carrier_src_t;

    typedef struct packed {
        logic       enable;
        logic       output_invert;
        logic       sw_bit;
        logic       high_carrier_invert;
        logic       high_carrier_edge_wait;
        logic       low_carrier_invert;
        logic       low_carrier_edge_wait;
        logic [4:0] high_carrier_code;
        logic [4:0] low_carrier_code;
        logic [4:0] modulation_source_code;
    } dsm_cfg_t;

    typedef enum {DSM_ON_LOW, DSM_WAIT_LOW_FALL, DSM_ON_HIGH, DSM_WAIT_HIGH_FALL} dsm_mix_state_t;
endpackage : dsm_pkg

// file: verilog/dsm_sync2.sv
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module dsm_sync2 #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             clk,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dsm_sync_state_t;

    dsm_sync_state_t st_r;
    dsm_sync_state_t st_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("dsm_sync2: WIDTH must be positive");
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta   = d;
        st_nxt.stable = st_r.meta;
    end

    // no reset: a synchroniser only follows its input
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign q = st_r.stable;
endmodule : dsm_sync2

// file: verilog/dsm_carrier_mux.sv
// carrier source multiplexer with reserved codes forced low
`timescale 1ns/1ps
`include "dsm_defines.svh"
module dsm_carrier_mux (
    // selection
    input  wire logic                      clk,
    input  wire logic [4:0]                code,
    input  wire logic                      sys_clk_level,
    input  wire dsm_pkg::dsm_carrier_src_t src,
    // registered carrier
    output logic                           carrier
);
    typedef struct packed {
        logic carrier;
    } dsm_mux_state_t;

    dsm_mux_state_t st_r;
    dsm_mux_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (code == `DSM_CODE_PIN) begin
            st_nxt.carrier = src.pin;
        end else if (code == `DSM_CODE_SYSCLK) begin
            st_nxt.carrier = sys_clk_level;
        end else if (code == `DSM_CODE_FASTOSC) begin
            st_nxt.carrier = src.fast_osc;
        end else if (code < `DSM_CODE_PWM_FIRST) begin
            st_nxt.carrier = src.ccp[2'(code - `DSM_CODE_CCP_FIRST)];
        end else if (code < `DSM_CODE_LC_FIRST) begin
            st_nxt.carrier = src.pwm[3'(code - `DSM_CODE_PWM_FIRST)];
        end else if (code <= `DSM_CODE_LAST) begin
            st_nxt.carrier = src.lc[2'(code - `DSM_CODE_LC_FIRST)];
        end else begin
            st_nxt.carrier = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign carrier = st_r.carrier;
endmodule : dsm_carrier_mux

// file: verilog/dsm_carrier_select.sv
// modulator carrier-select stage with AXI4-Lite registers and mixing logic
// Functional notes
// - high-carrier select register, bits 4..0 choose the high carrier source
// - low-carrier select register, bits 4..0 choose the low carrier source
// - codes map pin, clock, oscillator, capture, pulse, logic cells; 19 and up reserved
// - low-carrier codes use the same source mapping as high-carrier codes
// - bits 7..5 of carrier selectors ignore writes and read zero
// - selector fields are cleared to zero by power-on reset, kept across other resets
// - unsynchronised carriers may give short pulses; edge wait avoids them
// - control register bit layout for enable, status, polarity, software bit, sync
// - edge wait holds a carrier until its falling edge before switching
// - carrier invert bit flips the selected carrier before mixing
// - output invert flips modulator output so it idles high
// - high modulation level passes high carrier, low passes low carrier
`timescale 1ns/1ps
`include "dsm_defines.svh"
module dsm_carrier_select #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      RST,
    input  wire logic                      POR,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]         S_AXI_AWADDR,
    input  wire logic                      S_AXI_AWVALID,
    output logic                           S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0]               S_AXI_WDATA,
    input  wire logic [3:0]                S_AXI_WSTRB,
    input  wire logic                      S_AXI_WVALID,
    output logic                           S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]                     S_AXI_BRESP,
    output logic                           S_AXI_BVALID,
    input  wire logic                      S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]         S_AXI_ARADDR,
    input  wire logic                      S_AXI_ARVALID,
    output logic                           S_AXI_ARREADY,
    output logic [31:0]                    S_AXI_RDATA,
    output logic [1:0]                     S_AXI_RRESP,
    output logic                           S_AXI_RVALID,
    input  wire logic                      S_AXI_RREADY,
    // carrier and modulation sources
    input  wire dsm_pkg::dsm_carrier_src_t CARRIER_SRC,
    input  wire logic [31:0]               MOD_SRC,
    // modulator output
    output logic                           MOD_OUT
);
    typedef struct packed {
        dsm_pkg::dsm_cfg_t      cfg;
        dsm_pkg::dsm_mix_state_t mix;
        logic                   aw_got;
        logic [ADDR_W-1:0]      aw_addr;
        logic                   w_got;
        logic [31:0]            w_data;
        logic                   w_strb0;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic                   hi_prev;
        logic                   lo_prev;
        logic                   sys_div;
        logic                   out;
    } dsm_top_state_t;

    dsm_top_state_t st_r;
    dsm_top_state_t st_nxt;

    dsm_pkg::dsm_carrier_src_t src_sync;
    logic [31:0]               mod_sync;
    logic                      hi_raw;
    logic                      lo_raw;
    logic                      hi_car;
    logic                      lo_car;
    logic                      mod_level;
    logic                      sys_clk_level;

    // wider addresses would alias onto the map once cut to the 12-bit offsets
    if (ADDR_W < 5 || ADDR_W > 12) begin : g_bad_addr_w
        $error("dsm_carrier_select: ADDR_W must lie between 5 and 12");
    end

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [11:0] off;
        off = 12'(a);
        return off == `DSM_OFF_CON0 || off == `DSM_OFF_CON1 || off == `DSM_OFF_SRC ||
               off == `DSM_OFF_CARH || off == `DSM_OFF_CARL;
    endfunction : is_mapped

    dsm_sync2 #(.WIDTH($bits(dsm_pkg::dsm_carrier_src_t))) u_src_sync (
        .clk (CLOCK),
        .d   (CARRIER_SRC),
        .q   (src_sync)
    );

    dsm_sync2 #(.WIDTH(32)) u_mod_sync (
        .clk (CLOCK),
        .d   (MOD_SRC),
        .q   (mod_sync)
    );

    // the system clock itself cannot be sampled on its own edge; a toggle
    // at half rate stands in for it
    assign sys_clk_level = st_r.sys_div;

    dsm_carrier_mux u_high_mux (
        .clk           (CLOCK),
        .code          (st_r.cfg.high_carrier_code),
        .sys_clk_level (sys_clk_level),
        .src           (src_sync),
        .carrier       (hi_raw)
    );

    dsm_carrier_mux u_low_mux (
        .clk           (CLOCK),
        .code          (st_r.cfg.low_carrier_code),
        .sys_clk_level (sys_clk_level),
        .src           (src_sync),
        .carrier       (lo_raw)
    );

    assign hi_car = hi_raw ^ st_r.cfg.high_carrier_invert;
    assign lo_car = lo_raw ^ st_r.cfg.low_carrier_invert;

    always_comb begin
        mod_level = 1'b0;
        if (st_r.cfg.modulation_source_code == `DSM_MS_SWBIT) begin
            mod_level = st_r.cfg.sw_bit;
        end else if (st_r.cfg.modulation_source_code <= `DSM_MS_LAST) begin
            mod_level = mod_sync[st_r.cfg.modulation_source_code];
        end
    end

    always_comb begin
        logic        wr_fire;
        logic        mixed;
        logic [11:0] woff;
        logic [11:0] roff;
        logic [7:0]  wb;
        wr_fire = 1'b0;
        mixed   = 1'b0;
        woff    = 12'h000;
        roff    = 12'h000;
        wb      = 8'h00;
        st_nxt  = st_r;

        if (S_AXI_AWVALID && !st_r.aw_got) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !st_r.w_got) begin
            st_nxt.w_got   = 1'b1;
            st_nxt.w_data  = S_AXI_WDATA;
            st_nxt.w_strb0 = S_AXI_WSTRB[0];
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_fire       = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = is_mapped(st_r.aw_addr) ? `DSM_RESP_OKAY : `DSM_RESP_SLVERR;
        end
        if (st_r.bvalid && S_AXI_BREADY) begin
            st_nxt.bvalid = 1'b0;
        end

        // only the low byte lane holds register bits
        woff = 12'(st_r.aw_addr);
        wb   = st_r.w_data[7:0];
        if (wr_fire && st_r.w_strb0) begin
            case (woff)
                `DSM_OFF_CON0: begin
                    st_nxt.cfg.enable        = wb[`DSM_CON0_EN];
                    st_nxt.cfg.output_invert = wb[`DSM_CON0_OUTPUT_INVERT];
                    st_nxt.cfg.sw_bit        = wb[`DSM_CON0_BIT];
                end
                `DSM_OFF_CON1: begin
                    st_nxt.cfg.high_carrier_invert    = wb[`DSM_CON1_HIGH_CARRIER_INVERT];
                    st_nxt.cfg.high_carrier_edge_wait = wb[`DSM_CON1_HIGH_CARRIER_EDGE_WAIT];
                    st_nxt.cfg.low_carrier_invert     = wb[`DSM_CON1_LOW_CARRIER_INVERT];
                    st_nxt.cfg.low_carrier_edge_wait  = wb[`DSM_CON1_LOW_CARRIER_EDGE_WAIT];
                end
                `DSM_OFF_SRC:  st_nxt.cfg.modulation_source_code = wb[4:0];
                `DSM_OFF_CARH: st_nxt.cfg.high_carrier_code = wb[4:0];
                `DSM_OFF_CARL: st_nxt.cfg.low_carrier_code = wb[4:0];
                default: ;
            endcase
        end

        if (S_AXI_ARVALID && !st_r.rvalid) begin
            roff          = 12'(S_AXI_ARADDR);
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = is_mapped(S_AXI_ARADDR) ? `DSM_RESP_OKAY : `DSM_RESP_SLVERR;
            st_nxt.rdata  = 32'h0000_0000;
            case (roff)
                `DSM_OFF_CON0: begin
                    st_nxt.rdata[`DSM_CON0_EN]   = st_r.cfg.enable;
                    st_nxt.rdata[`DSM_CON0_OUT]  = st_r.out;
                    st_nxt.rdata[`DSM_CON0_OUTPUT_INVERT] = st_r.cfg.output_invert;
                    st_nxt.rdata[`DSM_CON0_BIT]  = st_r.cfg.sw_bit;
                end
                `DSM_OFF_CON1: begin
                    st_nxt.rdata[`DSM_CON1_HIGH_CARRIER_INVERT]  = st_r.cfg.high_carrier_invert;
                    st_nxt.rdata[`DSM_CON1_HIGH_CARRIER_EDGE_WAIT] = st_r.cfg.high_carrier_edge_wait;
                    st_nxt.rdata[`DSM_CON1_LOW_CARRIER_INVERT]  = st_r.cfg.low_carrier_invert;
                    st_nxt.rdata[`DSM_CON1_LOW_CARRIER_EDGE_WAIT] = st_r.cfg.low_carrier_edge_wait;
                end
                `DSM_OFF_SRC:  st_nxt.rdata[4:0] = st_r.cfg.modulation_source_code;
                `DSM_OFF_CARH: st_nxt.rdata[4:0] = st_r.cfg.high_carrier_code;
                `DSM_OFF_CARL: st_nxt.rdata[4:0] = st_r.cfg.low_carrier_code;
                default: ;
            endcase
        end
        if (st_r.rvalid && S_AXI_RREADY) begin
            st_nxt.rvalid = 1'b0;
        end

        // edge wait: a switch away from a carrier waits for that carrier's
        // falling edge so its last pulse is not cut short
        st_nxt.sys_div = ~st_r.sys_div;
        st_nxt.hi_prev = hi_car;
        st_nxt.lo_prev = lo_car;
        case (st_r.mix)
            dsm_pkg::DSM_ON_LOW: begin
                if (mod_level) begin
                    st_nxt.mix = st_r.cfg.low_carrier_edge_wait ? dsm_pkg::DSM_WAIT_LOW_FALL
                                                                : dsm_pkg::DSM_ON_HIGH;
                end
            end
            dsm_pkg::DSM_WAIT_LOW_FALL: begin
                if (!mod_level) begin
                    st_nxt.mix = dsm_pkg::DSM_ON_LOW;
                end else if (st_r.lo_prev && !lo_car) begin
                    st_nxt.mix = dsm_pkg::DSM_ON_HIGH;
                end
            end
            dsm_pkg::DSM_ON_HIGH: begin
                if (!mod_level) begin
                    st_nxt.mix = st_r.cfg.high_carrier_edge_wait ? dsm_pkg::DSM_WAIT_HIGH_FALL
                                                                 : dsm_pkg::DSM_ON_LOW;
                end
            end
            dsm_pkg::DSM_WAIT_HIGH_FALL: begin
                if (mod_level) begin
                    st_nxt.mix = dsm_pkg::DSM_ON_HIGH;
                end else if (st_r.hi_prev && !hi_car) begin
                    st_nxt.mix = dsm_pkg::DSM_ON_LOW;
                end
            end
            default: st_nxt.mix = dsm_pkg::DSM_ON_LOW;
        endcase

        case (st_r.mix)
            dsm_pkg::DSM_ON_HIGH, dsm_pkg::DSM_WAIT_HIGH_FALL: mixed = hi_car;
            default: mixed = lo_car;
        endcase
        if (!st_r.cfg.enable) begin
            mixed = 1'b0;
        end
        st_nxt.out = mixed ^ st_r.cfg.output_invert;
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r.cfg.enable                 <= 1'b0;
            st_r.cfg.output_invert          <= 1'b0;
            st_r.cfg.sw_bit                 <= 1'b0;
            st_r.cfg.high_carrier_invert    <= 1'b0;
            st_r.cfg.high_carrier_edge_wait <= 1'b0;
            st_r.cfg.low_carrier_invert     <= 1'b0;
            st_r.cfg.low_carrier_edge_wait  <= 1'b0;
            // selector codes keep their contents on ordinary resets
            if (POR) begin
                st_r.cfg.high_carrier_code      <= `DSM_CODE_RESET;
                st_r.cfg.low_carrier_code       <= `DSM_CODE_RESET;
                st_r.cfg.modulation_source_code <= `DSM_CODE_RESET;
            end else begin
                st_r.cfg.high_carrier_code      <= st_r.cfg.high_carrier_code;
                st_r.cfg.low_carrier_code       <= st_r.cfg.low_carrier_code;
                st_r.cfg.modulation_source_code <= st_r.cfg.modulation_source_code;
            end
            st_r.mix     <= dsm_pkg::DSM_ON_LOW;
            st_r.aw_got  <= 1'b0;
            st_r.aw_addr <= '0;
            st_r.w_got   <= 1'b0;
            st_r.w_data  <= 32'h0000_0000;
            st_r.w_strb0 <= 1'b0;
            st_r.bvalid  <= 1'b0;
            st_r.bresp   <= `DSM_RESP_OKAY;
            st_r.rvalid  <= 1'b0;
            st_r.rdata   <= 32'h0000_0000;
            st_r.rresp   <= `DSM_RESP_OKAY;
            st_r.hi_prev <= 1'b0;
            st_r.lo_prev <= 1'b0;
            st_r.sys_div <= 1'b0;
            st_r.out     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign S_AXI_AWREADY = !st_r.aw_got;
    assign S_AXI_WREADY  = !st_r.w_got;
    assign S_AXI_BVALID  = st_r.bvalid;
    assign S_AXI_BRESP   = st_r.bresp;
    assign S_AXI_ARREADY = !st_r.rvalid;
    assign S_AXI_RVALID  = st_r.rvalid;
    assign S_AXI_RDATA   = st_r.rdata;
    assign S_AXI_RRESP   = st_r.rresp;
    assign MOD_OUT       = st_r.out;
endmodule : dsm_carrier_select

// file: test/dsm_carrier_select_monitor.sv
// bus, register-field and output-level assertions for the carrier-select stage
`timescale 1ns/1ps
`include "dsm_defines.svh"
module dsm_carrier_select_monitor #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic              CLOCK,
    input wire logic              RST,
    // register bus
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [31:0]       S_AXI_RDATA,
    input wire logic [1:0]        S_AXI_RRESP,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY,
    input wire logic [1:0]        S_AXI_BRESP,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    // modulator output
    input wire logic              MOD_OUT
);
    logic [ADDR_W-1:0] rd_addr_r;
    logic              rd_ok;
    // read data carries no address, so keep the one of the read in flight
    always_ff @(posedge CLOCK) begin
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rd_addr_r <= S_AXI_ARADDR;
        end
    end
    assign rd_ok = S_AXI_RVALID && S_AXI_RRESP == `DSM_RESP_OKAY;
    default clocking mon_cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    AST_B_HOLD: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped or changed before taken");
    AST_R_HOLD: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped or changed before taken");
    AST_R_ANSWER: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered on the next cycle");
    AST_RESET_IDLE: assert property (
        $fell(RST) |-> !MOD_OUT && !S_AXI_BVALID && !S_AXI_RVALID)
        else $error("output or bus not idle after reset");
    AST_SEL_UPPER_ZERO: assert property (
        rd_ok && (rd_addr_r == `DSM_OFF_CARH || rd_addr_r == `DSM_OFF_CARL)
        |-> S_AXI_RDATA[31:5] == 27'h0)
        else $error("selector upper bits not zero");
    AST_CON0_FIELDS: assert property (
        rd_ok && rd_addr_r == `DSM_OFF_CON0
        |-> S_AXI_RDATA[31:8] == 24'h0 && !S_AXI_RDATA[6] && S_AXI_RDATA[3:1] == 3'h0)
        else $error("control 0 unused bits not zero");
    AST_CON1_FIELDS: assert property (
        rd_ok && rd_addr_r == `DSM_OFF_CON1
        |-> S_AXI_RDATA[31:6] == 26'h0 && S_AXI_RDATA[3:2] == 2'h0)
        else $error("control 1 unused bits not zero");
    AST_IDLE_LEVEL: assert property (
        rd_ok && rd_addr_r == `DSM_OFF_CON0 && !S_AXI_RDATA[7]
        |-> S_AXI_RDATA[5] == S_AXI_RDATA[4])
        else $error("disabled output not at its idle level");
endmodule : dsm_carrier_select_monitor

bind dsm_carrier_select dsm_carrier_select_monitor #(.ADDR_W(ADDR_W)) mon_u (
    .CLOCK, .RST, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .MOD_OUT
);

// file: test/dsm_src_model.sv
// stand-in for the on-chip carrier and modulation sources
`timescale 1ns/1ps
module dsm_src_model (
    // levels asked for by the bench
    input  wire logic                      clk,
    input  wire dsm_pkg::dsm_carrier_src_t src_set,
    input  wire logic [31:0]               mod_set,
    // levels towards the block
    output dsm_pkg::dsm_carrier_src_t      src,
    output logic [31:0]                    mod
);
    // the real sources are clocked logic, so levels change only at an edge
    always_ff @(posedge clk) begin
        src <= src_set;
        mod <= mod_set;
    end
endmodule : dsm_src_model

// file: test/dsm_carrier_select_tb_top.sv
// self-checking bench for the carrier-select stage
`timescale 1ns/1ps
`include "dsm_defines.svh"
module dsm_carrier_select_tb_top;
    logic                      clock = 1'b0;
    logic                      rst = 1'b1;
    logic                      por = 1'b1;
    logic [11:0]               aw_addr = 12'h0, ar_addr = 12'h0;
    logic                      aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
    logic                      ar_valid = 1'b0, r_ready = 1'b0;
    logic [31:0]               w_data = 32'h0, mod_set = 32'h0, r_data, mod, rng = 32'h12;
    logic [3:0]                w_strb = 4'hF;
    logic                      aw_ready, w_ready, b_valid, ar_ready, r_valid, mod_out;
    logic [1:0]                b_resp, r_resp;
    dsm_pkg::dsm_carrier_src_t src_set = '0;
    dsm_pkg::dsm_carrier_src_t src;
    logic [33:0]               exp_q[$];
    int                        n_mismatch = 0, checks = 0, cycles = 0;

    dsm_src_model src_u (.clk(clock), .src_set(src_set), .mod_set(mod_set), .src(src), .mod(mod));
    dsm_carrier_select #(.ADDR_W(12)) dut_u (
        .CLOCK(clock), .RST(rst), .POR(por),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
        .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
        .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
        .CARRIER_SRC(src), .MOD_SRC(mod), .MOD_OUT(mod_out)
    );

    always #25 clock = ~clock;

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // results are judged in bus order, one note per answer
    always @(posedge clock) begin
        if (b_valid && b_ready) check({b_resp, 32'h0}, exp_q.pop_front());
        if (r_valid && r_ready) check({r_resp, r_data}, exp_q.pop_front());
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        exp_q.push_back({r, 32'h0});
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= {24'h0, d};
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge clock);
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
        end while (!(b_valid && b_ready));
        b_ready <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        exp_q.push_back({r, 24'h0, d});
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge clock);
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
        end while (!(r_valid && r_ready));
        r_ready <= 1'b0;
        @(posedge clock);
    endtask : rd

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    // the carrier a code should route, worked out from the source table
    function automatic logic carrier_of(input logic [4:0] c, input dsm_pkg::dsm_carrier_src_t s);
        if (c == 5'h00) return s.pin;
        if (c == 5'h02) return s.fast_osc;
        if (c >= 5'h03 && c <= 5'h06) return s.ccp[c - 5'h03];
        if (c >= 5'h07 && c <= 5'h0E) return s.pwm[c - 5'h07];
        if (c >= 5'h0F && c <= 5'h12) return s.lc[c - 5'h0F];
        return 1'b0;
    endfunction : carrier_of

    // every code but the clock one, with random source levels; status shows the carrier
    task automatic sweep(input logic high);
        logic [4:0] c;
        for (int i = 0; i < 32; i++) begin
            c = 5'(i);
            // the clock code is skipped: its carrier toggles every cycle, so there is no fixed level to check
            if (c != `DSM_CODE_SYSCLK) begin
                rng = xs(rng);
                src_set <= dsm_pkg::dsm_carrier_src_t'(rng[17:0]);
                mod_set <= xs(rng);
                wr(high ? `DSM_OFF_CARH : `DSM_OFF_CARL, {3'h7, c});
                idle(8);
                rd(`DSM_OFF_CON0, {2'h2, carrier_of(c, rng[17:0]), 4'h0, high});
            end
        end
    endtask : sweep

    initial begin
        idle(8);
        rst <= 1'b0;
        por <= 1'b0;
        rd(`DSM_OFF_CON0, 8'h00);
        rd(`DSM_OFF_CARH, 8'h00);
        wr(12'h014, 8'hFF, `DSM_RESP_SLVERR);
        rd(12'h014, 8'h00, `DSM_RESP_SLVERR);
        wr(`DSM_OFF_CON1, 8'hFF);
        rd(`DSM_OFF_CON1, 8'h33);
        wr(`DSM_OFF_CON1, 8'h00);
        wr(`DSM_OFF_SRC, 8'h01);
        wr(`DSM_OFF_CON0, 8'h81);
        sweep(1'b1);
        wr(`DSM_OFF_CON0, 8'h80);
        sweep(1'b0);
        // both carriers now on a reserved code, so inversion alone makes them high
        wr(`DSM_OFF_CON1, 8'h20);
        wr(`DSM_OFF_CON0, 8'h81);
        idle(8);
        rd(`DSM_OFF_CON0, 8'hA1);
        wr(`DSM_OFF_CON1, 8'h02);
        wr(`DSM_OFF_CON0, 8'h80);
        idle(8);
        rd(`DSM_OFF_CON0, 8'hA0);
        wr(`DSM_OFF_CON0, 8'h10);
        idle(8);
        rd(`DSM_OFF_CON0, 8'h30);
        // high carrier from the pin held high, low carrier from the oscillator held low
        src_set <= dsm_pkg::dsm_carrier_src_t'(18'h20000);
        wr(`DSM_OFF_CARH, 8'h00);
        wr(`DSM_OFF_CARL, 8'h02);
        wr(`DSM_OFF_CON1, 8'h10);
        wr(`DSM_OFF_CON0, 8'h81);
        idle(8);
        rd(`DSM_OFF_CON0, 8'hA1);
        wr(`DSM_OFF_CON0, 8'h80);
        idle(8);
        rd(`DSM_OFF_CON0, 8'hA0);
        src_set <= '0;
        idle(8);
        rd(`DSM_OFF_CON0, 8'h80);
        w_strb <= 4'h0;
        wr(`DSM_OFF_CARH, 8'h05);
        w_strb <= 4'hF;
        rd(`DSM_OFF_CARH, 8'h00);
        wr(`DSM_OFF_CARH, 8'hE1);
        wr(`DSM_OFF_CARL, 8'h12);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rd(`DSM_OFF_CARH, 8'h01);
        rd(`DSM_OFF_CARL, 8'h12);
        rd(`DSM_OFF_CON1, 8'h00);
        por <= 1'b1;
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        por <= 1'b0;
        rd(`DSM_OFF_CARL, 8'h00);
        tally_and_finish();
    end
endmodule : dsm_carrier_select_tb_top
